// ---- pkg/agp_pkg.sv ----
/*
 * agp_pkg: constants of the audio, gpio, pwm and command pointer register
 * slice: byte offsets, widths, reset values and timing counts.
 * assumes a 22-bit host byte address and a 20 MHz system clock.
 */
// Overview of operation
// - each direction bit makes its pin an input when 0, an output when 1
// - pin value sits in bits 0, 1 and 7; bits 2 to 6 set drive strength
// - interrupt flags are read only and a host read of them clears all
// - backlight duty scales linearly; 0 is always low, 128 and up always high
// - backlight frequency in hertz, 14-bit read-write, resets to 250
// - touch select 0 is multi-touch extended, 1 single-touch; resets to 1
// - playback rate in hertz, 16-bit read-write, resets to 8000
// - playback length in bytes, 20-bit read-write, resets to zero
// - current fetch position readable as a 20-bit read-only pointer
// - loop bit, cleared at reset, restarts playback at start after last byte
// - command consumer pointer is 12-bit read-write, resets to zero
// - host advances 12-bit write pointer; device works up to that position
// - display-list write offset is 13-bit read-write, resets to zero
// - two 32-bit read-write macro words, reset to zero
package agp_pkg;

	// ****************************************
	// bus shape
	// ****************************************
	localparam int ADDR_W = 22;
	localparam int DATA_W = 32;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [21:0] OFF_PLAY_VOL = 22'h10_247c;
	localparam logic [21:0] OFF_FX_VOL = 22'h10_2480;
	localparam logic [21:0] OFF_FX_SEL = 22'h10_2484;
	localparam logic [21:0] OFF_PIN_DIR = 22'h10_248c;
	localparam logic [21:0] OFF_PIN_VAL = 22'h10_2490;
	localparam logic [21:0] OFF_INT_EN = 22'h10_2494;
	localparam logic [21:0] OFF_INT_FLAG = 22'h10_2498;
	localparam logic [21:0] OFF_INT_MASK = 22'h10_249c;
	localparam logic [21:0] OFF_PLAY_START = 22'h10_24a0;
	localparam logic [21:0] OFF_PLAY_LEN = 22'h10_24a8;
	localparam logic [21:0] OFF_PLAY_PTR = 22'h10_24ac;
	localparam logic [21:0] OFF_PLAY_RATE = 22'h10_24b0;
	localparam logic [21:0] OFF_PLAY_ENC = 22'h10_24b4;
	localparam logic [21:0] OFF_PLAY_LOOP = 22'h10_24b8;
	localparam logic [21:0] OFF_PLAY_GO = 22'h10_24bc;
	localparam logic [21:0] OFF_BL_FREQ = 22'h10_24c0;
	localparam logic [21:0] OFF_BL_DUTY = 22'h10_24c4;
	localparam logic [21:0] OFF_MACRO0 = 22'h10_24c8;
	localparam logic [21:0] OFF_MACRO1 = 22'h10_24cc;
	localparam logic [21:0] OFF_CAP_LO = 22'h10_24d8;
	localparam logic [21:0] OFF_CAP_HI = 22'h10_24dc;
	localparam logic [21:0] OFF_CMD_RD = 22'h10_24e4;
	localparam logic [21:0] OFF_CMD_WR = 22'h10_24e8;
	localparam logic [21:0] OFF_CMD_DL = 22'h10_24ec;
	localparam logic [21:0] OFF_TOUCH_MODE = 22'h10_24f0;
	localparam logic [21:0] OFF_TOUCH_SEL = 22'h10_24f4;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_PLAY_VOL = 8'hff;
	localparam logic [7:0] RST_FX_VOL = 8'hff;
	localparam logic [15:0] RST_FX_SEL = 16'h0000;
	localparam logic [7:0] RST_PIN_DIR = 8'h80;
	localparam logic [7:0] RST_PIN_VAL = 8'h00;
	localparam logic [7:0] RST_INT_MASK = 8'hff;
	localparam logic [19:0] RST_PLAY_START = 20'h0_0000;
	localparam logic [19:0] RST_PLAY_LEN = 20'h0_0000;
	localparam logic [15:0] RST_PLAY_RATE = 16'h1f40;
	localparam logic [1:0] RST_PLAY_ENC = 2'h0;
	localparam logic [13:0] RST_BL_FREQ = 14'h00fa;
	localparam logic [7:0] RST_BL_DUTY = 8'h80;
	localparam logic [31:0] RST_MACRO = 32'h0000_0000;
	localparam logic [11:0] RST_CMD_PTR = 12'h000;
	localparam logic [12:0] RST_CMD_DL = 13'h0000;
	localparam logic [1:0] RST_TOUCH_MODE = 2'h3;
	localparam logic RST_TOUCH_SEL = 1'b1;

	// ****************************************
	// gpio field layout
	// ****************************************
	localparam int PIN_CNT = 3;
	localparam int PIN_POS0 = 0;
	localparam int PIN_POS1 = 1;
	localparam int PIN_POS2 = 7;
	localparam int DRIVE_LSB = 2;
	localparam int DRIVE_W = 5;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int ACC_W = 25;
	localparam logic [24:0] CLK_HZ_ACC = 25'(CLK_HZ);
	localparam int DUTY_STEPS = 128;
	localparam logic [7:0] DUTY_FULL = 8'h80;

endpackage : agp_pkg

// ---- verilog/agp_backlight.sv ----
/*
 * agp_backlight: backlight pwm generator driven by frequency and duty.
 * assumes frequency in hertz and duty in 1/128 steps, both held stable
 * by the register bank.
 */
`timescale 1ns/1ps
module agp_backlight (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [13:0] freq_hz_i,
	input wire logic [7:0] duty_i,
	output logic pwm_o
);

	// ****************************************
	// phase stepping
	// ****************************************
	// a fractional accumulator avoids a divider: 128 phase steps per period
	logic [24:0] acc_reg;
	logic [24:0] acc_next;
	logic [6:0] phase_reg;
	logic [24:0] acc_sum;
	logic step;
	logic level;

	assign acc_sum = acc_reg + 25'({freq_hz_i, 7'h00});
	assign step = acc_sum >= agp_pkg::CLK_HZ_ACC;
	assign acc_next = step ? acc_sum - agp_pkg::CLK_HZ_ACC : acc_sum;
	// duty of 128 or more never drops; zero never rises
	assign level = (duty_i >= agp_pkg::DUTY_FULL) ||
		({1'b0, phase_reg} < duty_i);

	// accumulator, phase and output flops
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			acc_reg <= 25'h000_0000;
			phase_reg <= 7'h00;
			pwm_o <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			phase_reg <= phase_reg + 7'(step);
			pwm_o <= level;
		end
	end
endmodule : agp_backlight

// ---- verilog/agp_regs.sv ----
/*
 * agp_regs: host register bank for audio volume and playback, effect
 * trigger, gpio, interrupt flags, backlight pwm, display-list macros,
 * screenshot ready flags, command pointers and touch mode.
 * assumes a host access port synchronous to clk_sys_i, one access a cycle,
 * and engines behind the outputs that keep their own protocols.
 */
`timescale 1ns/1ps
module agp_regs (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [21:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic [2:0] gpio_in_i,
	output logic [2:0] gpio_out_o,
	output logic [2:0] gpio_oe_o,
	output logic [4:0] gpio_drive_o,
	input wire logic [7:0] int_event_i,
	output logic irq_o,
	output logic backlight_pwm_o,
	output logic [7:0] play_volume_o,
	output logic [7:0] fx_volume_o,
	output logic [15:0] fx_select_o,
	output logic fx_start_o,
	output logic [19:0] play_fetch_addr_o,
	output logic play_tick_o,
	output logic play_active_o,
	output logic [1:0] play_encoding_o,
	input wire logic cmd_read_adv_i,
	output logic cmd_pending_o,
	output logic [11:0] cmd_read_ptr_o,
	output logic [11:0] cmd_write_ptr_o,
	input wire logic cmd_dl_load_i,
	input wire logic [12:0] cmd_dl_value_i,
	output logic [12:0] cmd_dl_offset_o,
	output logic [31:0] macro0_o,
	output logic [31:0] macro1_o,
	input wire logic [63:0] capture_ready_i,
	output logic [1:0] touch_mode_o,
	output logic touch_select_o
);

	// ****************************************
	// address decode
	// ****************************************
	logic hit_play_vol;
	logic hit_fx_vol;
	logic hit_fx_sel;
	logic hit_pin_dir;
	logic hit_pin_val;
	logic hit_int_en;
	logic hit_int_flag;
	logic hit_int_mask;
	logic hit_play_start;
	logic hit_play_len;
	logic hit_play_ptr;
	logic hit_play_rate;
	logic hit_play_enc;
	logic hit_play_loop;
	logic hit_play_go;
	logic hit_bl_freq;
	logic hit_bl_duty;
	logic hit_macro0;
	logic hit_macro1;
	logic hit_cap_lo;
	logic hit_cap_hi;
	logic hit_cmd_rd;
	logic hit_cmd_wr;
	logic hit_cmd_dl;
	logic hit_touch_mode;
	logic hit_touch_sel;

	// one compare per register; unmapped addresses match nothing
	assign hit_play_vol = reg_addr_i == agp_pkg::OFF_PLAY_VOL;
	assign hit_fx_vol = reg_addr_i == agp_pkg::OFF_FX_VOL;
	assign hit_fx_sel = reg_addr_i == agp_pkg::OFF_FX_SEL;
	assign hit_pin_dir = reg_addr_i == agp_pkg::OFF_PIN_DIR;
	assign hit_pin_val = reg_addr_i == agp_pkg::OFF_PIN_VAL;
	assign hit_int_en = reg_addr_i == agp_pkg::OFF_INT_EN;
	assign hit_int_flag = reg_addr_i == agp_pkg::OFF_INT_FLAG;
	assign hit_int_mask = reg_addr_i == agp_pkg::OFF_INT_MASK;
	assign hit_play_start = reg_addr_i == agp_pkg::OFF_PLAY_START;
	assign hit_play_len = reg_addr_i == agp_pkg::OFF_PLAY_LEN;
	assign hit_play_ptr = reg_addr_i == agp_pkg::OFF_PLAY_PTR;
	assign hit_play_rate = reg_addr_i == agp_pkg::OFF_PLAY_RATE;
	assign hit_play_enc = reg_addr_i == agp_pkg::OFF_PLAY_ENC;
	assign hit_play_loop = reg_addr_i == agp_pkg::OFF_PLAY_LOOP;
	assign hit_play_go = reg_addr_i == agp_pkg::OFF_PLAY_GO;
	assign hit_bl_freq = reg_addr_i == agp_pkg::OFF_BL_FREQ;
	assign hit_bl_duty = reg_addr_i == agp_pkg::OFF_BL_DUTY;
	assign hit_macro0 = reg_addr_i == agp_pkg::OFF_MACRO0;
	assign hit_macro1 = reg_addr_i == agp_pkg::OFF_MACRO1;
	assign hit_cap_lo = reg_addr_i == agp_pkg::OFF_CAP_LO;
	assign hit_cap_hi = reg_addr_i == agp_pkg::OFF_CAP_HI;
	assign hit_cmd_rd = reg_addr_i == agp_pkg::OFF_CMD_RD;
	assign hit_cmd_wr = reg_addr_i == agp_pkg::OFF_CMD_WR;
	assign hit_cmd_dl = reg_addr_i == agp_pkg::OFF_CMD_DL;
	assign hit_touch_mode = reg_addr_i == agp_pkg::OFF_TOUCH_MODE;
	assign hit_touch_sel = reg_addr_i == agp_pkg::OFF_TOUCH_SEL;

	// ****************************************
	// plain read-write registers
	// ****************************************
	logic [7:0] pin_dir_reg;
	logic [7:0] pin_val_reg;
	logic int_en_reg;
	logic [7:0] int_mask_reg;
	logic [19:0] play_start_reg;
	logic [19:0] play_len_reg;
	logic [15:0] play_rate_reg;
	logic play_loop_reg;
	logic [13:0] bl_freq_reg;
	logic [7:0] bl_duty_reg;

	// host writes; the write port has no byte enables, words land whole
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			play_volume_o <= agp_pkg::RST_PLAY_VOL;
			fx_volume_o <= agp_pkg::RST_FX_VOL;
			fx_select_o <= agp_pkg::RST_FX_SEL;
			pin_dir_reg <= agp_pkg::RST_PIN_DIR;
			pin_val_reg <= agp_pkg::RST_PIN_VAL;
			int_en_reg <= 1'b0;
			int_mask_reg <= agp_pkg::RST_INT_MASK;
			play_start_reg <= agp_pkg::RST_PLAY_START;
			play_len_reg <= agp_pkg::RST_PLAY_LEN;
			play_rate_reg <= agp_pkg::RST_PLAY_RATE;
			play_encoding_o <= agp_pkg::RST_PLAY_ENC;
			play_loop_reg <= 1'b0;
			bl_freq_reg <= agp_pkg::RST_BL_FREQ;
			bl_duty_reg <= agp_pkg::RST_BL_DUTY;
			macro0_o <= agp_pkg::RST_MACRO;
			macro1_o <= agp_pkg::RST_MACRO;
			cmd_write_ptr_o <= agp_pkg::RST_CMD_PTR;
			touch_mode_o <= agp_pkg::RST_TOUCH_MODE;
			touch_select_o <= agp_pkg::RST_TOUCH_SEL;
		end else if (reg_wr_i) begin
			if (hit_play_vol) play_volume_o <= reg_wdata_i[7:0];
			if (hit_fx_vol) fx_volume_o <= reg_wdata_i[7:0];
			if (hit_fx_sel) fx_select_o <= reg_wdata_i[15:0];
			if (hit_pin_dir) pin_dir_reg <= reg_wdata_i[7:0];
			if (hit_pin_val) pin_val_reg <= reg_wdata_i[7:0];
			if (hit_int_en) int_en_reg <= reg_wdata_i[0];
			if (hit_int_mask) int_mask_reg <= reg_wdata_i[7:0];
			if (hit_play_start) play_start_reg <= reg_wdata_i[19:0];
			if (hit_play_len) play_len_reg <= reg_wdata_i[19:0];
			if (hit_play_rate) play_rate_reg <= reg_wdata_i[15:0];
			if (hit_play_enc) play_encoding_o <= reg_wdata_i[1:0];
			if (hit_play_loop) play_loop_reg <= reg_wdata_i[0];
			if (hit_bl_freq) bl_freq_reg <= reg_wdata_i[13:0];
			if (hit_bl_duty) bl_duty_reg <= reg_wdata_i[7:0];
			if (hit_macro0) macro0_o <= reg_wdata_i;
			if (hit_macro1) macro1_o <= reg_wdata_i;
			if (hit_cmd_wr) cmd_write_ptr_o <= reg_wdata_i[11:0];
			if (hit_touch_mode) touch_mode_o <= reg_wdata_i[1:0];
			if (hit_touch_sel) touch_select_o <= reg_wdata_i[0];
		end
	end

	// effect trigger: any write to the select register fires one pulse
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			fx_start_o <= 1'b0;
		end else begin
			fx_start_o <= reg_wr_i && hit_fx_sel;
		end
	end

	// ****************************************
	// gpio pins
	// ****************************************
	logic [7:0] pin_view;
	logic [2:0] pin_out_next;
	logic [2:0] pin_oe_next;

	// pin bits read the pad when input, the latch when output
	genvar gi;
	generate
		for (gi = 0; gi < agp_pkg::PIN_CNT; gi++) begin : g_pin
			localparam int POS = (gi == 0) ? agp_pkg::PIN_POS0 :
				(gi == 1) ? agp_pkg::PIN_POS1 : agp_pkg::PIN_POS2;
			assign pin_oe_next[gi] = pin_dir_reg[POS];
			assign pin_out_next[gi] = pin_val_reg[POS];
			assign pin_view[POS] = pin_dir_reg[POS] ? pin_val_reg[POS] :
				gpio_in_i[gi];
		end
	endgenerate
	// strength bits read back as written
	assign pin_view[6:2] = pin_val_reg[6:2];

	// pad drivers registered so outputs come straight from flops
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			gpio_out_o <= 3'h0;
			gpio_oe_o <= 3'h0;
			gpio_drive_o <= 5'h00;
		end else begin
			gpio_out_o <= pin_out_next;
			gpio_oe_o <= pin_oe_next;
			gpio_drive_o <= pin_val_reg[6:2];
		end
	end

	// ****************************************
	// interrupt flags
	// ****************************************
	logic [7:0] int_flag_reg;
	logic flag_rd;
	logic [7:0] int_flag_next;

	// a read clears, but an event in that same cycle still sets
	assign flag_rd = reg_rd_i && hit_int_flag;
	assign int_flag_next = (flag_rd ? 8'h00 : int_flag_reg) | int_event_i;

	// flags are never host written; only events and reads move them
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			int_flag_reg <= 8'h00;
			irq_o <= 1'b0;
		end else begin
			int_flag_reg <= int_flag_next;
			irq_o <= int_en_reg && |(int_flag_next & int_mask_reg);
		end
	end

	// ****************************************
	// audio playback
	// ****************************************
	logic play_go_reg;
	logic [19:0] play_ofs_reg;
	logic [24:0] rate_acc_reg;
	logic [24:0] rate_sum;
	logic rate_step;
	logic go_wr;
	logic last_byte;
	logic [19:0] play_len_last;

	assign go_wr = reg_wr_i && hit_play_go && reg_wdata_i[0];
	assign rate_sum = rate_acc_reg + 25'(play_rate_reg);
	assign rate_step = play_go_reg && (rate_sum >= agp_pkg::CLK_HZ_ACC);
	assign play_len_last = play_len_reg - 20'h0_0001;
	// a zero length ends at once rather than wrapping the whole space
	assign last_byte = (play_len_reg == 20'h0_0000) ||
		(play_ofs_reg >= play_len_last);

	// rate accumulator only runs while playing, so each start from stop is in phase
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || !play_go_reg) begin
			rate_acc_reg <= 25'h000_0000;
		end else begin
			rate_acc_reg <= rate_step ? rate_sum - agp_pkg::CLK_HZ_ACC :
				rate_sum;
		end
	end

	// go bit and byte offset; a fresh start wins over the step
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			play_go_reg <= 1'b0;
			play_ofs_reg <= 20'h0_0000;
		end else if (go_wr) begin
			play_go_reg <= 1'b1;
			play_ofs_reg <= 20'h0_0000;
		end else if (rate_step && last_byte) begin
			play_go_reg <= play_loop_reg;
			play_ofs_reg <= 20'h0_0000;
		end else if (rate_step) begin
			play_ofs_reg <= play_ofs_reg + 20'h0_0001;
		end
	end

	// fetch address and tick toward the audio engine
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			play_fetch_addr_o <= 20'h0_0000;
			play_tick_o <= 1'b0;
			play_active_o <= 1'b0;
		end else begin
			play_fetch_addr_o <= play_start_reg + play_ofs_reg;
			play_tick_o <= rate_step;
			play_active_o <= play_go_reg;
		end
	end

	// ****************************************
	// command pointers
	// ****************************************
	logic [11:0] cmd_read_next;
	logic [12:0] cmd_dl_next;

	// a host write wins over an engine advance in the same cycle
	assign cmd_read_next = (reg_wr_i && hit_cmd_rd) ? reg_wdata_i[11:0] :
		cmd_read_adv_i ? cmd_read_ptr_o + 12'h001 : cmd_read_ptr_o;
	assign cmd_dl_next = (reg_wr_i && hit_cmd_dl) ? reg_wdata_i[12:0] :
		cmd_dl_load_i ? cmd_dl_value_i : cmd_dl_offset_o;

	// pending tells the engine there is work up to the host's pointer
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cmd_read_ptr_o <= agp_pkg::RST_CMD_PTR;
			cmd_dl_offset_o <= agp_pkg::RST_CMD_DL;
			cmd_pending_o <= 1'b0;
		end else begin
			cmd_read_ptr_o <= cmd_read_next;
			cmd_dl_offset_o <= cmd_dl_next;
			cmd_pending_o <= cmd_read_ptr_o != cmd_write_ptr_o;
		end
	end

	// ****************************************
	// backlight
	// ****************************************
	agp_backlight u_backlight (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.freq_hz_i(bl_freq_reg),
		.duty_i(bl_duty_reg),
		.pwm_o(backlight_pwm_o)
	);

	// ****************************************
	// read path
	// ****************************************
	logic [31:0] rd_mux;

	// and-or select; unmapped addresses and reserved bits read zero
	assign rd_mux =
		({32{hit_play_vol}} & {24'h00_0000, play_volume_o}) |
		({32{hit_fx_vol}} & {24'h00_0000, fx_volume_o}) |
		({32{hit_fx_sel}} & {16'h0000, fx_select_o}) |
		({32{hit_pin_dir}} & {24'h00_0000, pin_dir_reg}) |
		({32{hit_pin_val}} & {24'h00_0000, pin_view}) |
		({32{hit_int_en}} & {31'h0000_0000, int_en_reg}) |
		({32{hit_int_flag}} & {24'h00_0000, int_flag_reg}) |
		({32{hit_int_mask}} & {24'h00_0000, int_mask_reg}) |
		({32{hit_play_start}} & {12'h000, play_start_reg}) |
		({32{hit_play_len}} & {12'h000, play_len_reg}) |
		({32{hit_play_ptr}} & {12'h000, play_fetch_addr_o}) |
		({32{hit_play_rate}} & {16'h0000, play_rate_reg}) |
		({32{hit_play_enc}} & {30'h0000_0000, play_encoding_o}) |
		({32{hit_play_loop}} & {31'h0000_0000, play_loop_reg}) |
		({32{hit_play_go}} & {31'h0000_0000, play_go_reg}) |
		({32{hit_bl_freq}} & {18'h0_0000, bl_freq_reg}) |
		({32{hit_bl_duty}} & {24'h00_0000, bl_duty_reg}) |
		({32{hit_macro0}} & macro0_o) |
		({32{hit_macro1}} & macro1_o) |
		({32{hit_cap_lo}} & capture_ready_i[31:0]) |
		({32{hit_cap_hi}} & capture_ready_i[63:32]) |
		({32{hit_cmd_rd}} & {20'h0_0000, cmd_read_ptr_o}) |
		({32{hit_cmd_wr}} & {20'h0_0000, cmd_write_ptr_o}) |
		({32{hit_cmd_dl}} & {19'h0_0000, cmd_dl_offset_o}) |
		({32{hit_touch_mode}} & {30'h0000_0000, touch_mode_o}) |
		({32{hit_touch_sel}} & {31'h0000_0000, touch_select_o});

	// read data registered; it holds until the next read
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 32'h0000_0000;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) reg_rdata_o <= rd_mux;
		end
	end

endmodule : agp_regs

// ---- bench/agp_regs_sva.sv ----
/* agp_regs_sva: assertions on host port, gpio, interrupt, playback and
   command pointer outputs of agp_regs.
   assumes a bind onto agp_regs and a whole-cycle synchronous reset. */
`timescale 1ns/1ps
module agp_regs_sva (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [21:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic reg_rvalid_o,
	input wire logic [2:0] gpio_out_o,
	input wire logic [2:0] gpio_oe_o,
	input wire logic [4:0] gpio_drive_o,
	input wire logic [7:0] int_event_i,
	input wire logic irq_o,
	input wire logic play_active_o,
	input wire logic cmd_read_adv_i,
	input wire logic cmd_pending_o,
	input wire logic [11:0] cmd_read_ptr_o,
	input wire logic [11:0] cmd_write_ptr_o,
	input wire logic cmd_dl_load_i,
	input wire logic [12:0] cmd_dl_value_i,
	input wire logic [12:0] cmd_dl_offset_o,
	input wire logic [31:0] macro0_o
);
	// ****************************************
	// write and read decode
	// ****************************************
	// host writes beat engine updates
	wire w_dir = reg_wr_i && reg_addr_i == agp_pkg::OFF_PIN_DIR;
	wire w_val = reg_wr_i && reg_addr_i == agp_pkg::OFF_PIN_VAL;
	wire w_go = reg_wr_i && reg_addr_i == agp_pkg::OFF_PLAY_GO;
	wire w_mac = reg_wr_i && reg_addr_i == agp_pkg::OFF_MACRO0;
	wire w_crd = reg_wr_i && reg_addr_i == agp_pkg::OFF_CMD_RD;
	wire w_cdl = reg_wr_i && reg_addr_i == agp_pkg::OFF_CMD_DL;
	wire r_flg = reg_rd_i && reg_addr_i == agp_pkg::OFF_INT_FLAG;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// ****************************************
	// properties
	// ****************************************
	dir_to_oe_a: assert property (w_dir |-> ##2 gpio_oe_o ==
		{$past(reg_wdata_i[7], 2), $past(reg_wdata_i[1:0], 2)})
		else $error("pin enables do not follow direction write");
	gpio_fields_a: assert property (w_val |-> ##2 gpio_out_o ==
		{$past(reg_wdata_i[7], 2), $past(reg_wdata_i[1:0], 2)}
		&& gpio_drive_o == $past(reg_wdata_i[6:2], 2))
		else $error("pin value or drive fields misplaced");
	rd_answer_a: assert property (reg_rvalid_o == $past(reg_rd_i))
		else $error("read answer not one cycle after strobe");
	flag_clear_a: assert property (r_flg && int_event_i == 8'h00
		|=> !irq_o) else $error("interrupt stays after flag read");
	irq_cause_a: assert property (!irq_o && int_event_i == 8'h00
		&& !reg_wr_i |=> !irq_o) else $error("interrupt rose uncaused");
	go_active_a: assert property (w_go && reg_wdata_i[0]
		|=> ##1 play_active_o) else $error("playback did not start");
	ptr_step_a: assert property (cmd_read_adv_i && !w_crd |=>
		cmd_read_ptr_o == $past(cmd_read_ptr_o) + 12'h001)
		else $error("consumer pointer did not advance by one");
	pend_lag_a: assert property (cmd_pending_o ==
		($past(cmd_read_ptr_o) != $past(cmd_write_ptr_o)))
		else $error("pending flag disagrees with pointers");
	dl_load_a: assert property (cmd_dl_load_i && !w_cdl |=>
		cmd_dl_offset_o == $past(cmd_dl_value_i))
		else $error("list offset load lost");
	macro_wr_a: assert property (w_mac |=>
		macro0_o == $past(reg_wdata_i)) else $error("macro word not held");
	// main scenarios reached
	irq_seen_c: cover property ($rose(irq_o));
	play_seen_c: cover property ($rose(play_active_o));
	pend_seen_c: cover property ($rose(cmd_pending_o));
endmodule : agp_regs_sva

// ---- bench/tb_audio_gpio_pwm_cmd_regs.sv ----
/* tb_audio_gpio_pwm_cmd_regs: directed register tests of agp_regs.
   assumes agp_pkg is compiled first; inputs move on the falling edge. */
`timescale 1ns/1ps
bind agp_regs agp_regs_sva i_sva (.clk_sys_i, .resetn_i, .reg_addr_i,
	.reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rvalid_o, .gpio_out_o,
	.gpio_oe_o, .gpio_drive_o, .int_event_i, .irq_o, .play_active_o,
	.cmd_read_adv_i, .cmd_pending_o, .cmd_read_ptr_o, .cmd_write_ptr_o,
	.cmd_dl_load_i, .cmd_dl_value_i, .cmd_dl_offset_o, .macro0_o);
module tb_audio_gpio_pwm_cmd_regs;
	logic clk_sys_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, irq_o;
	logic backlight_pwm_o, play_active_o, cmd_read_adv_i, cmd_pending_o;
	logic cmd_dl_load_i;
	logic [21:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, v;
	logic [2:0] gpio_in_i, gpio_out_o, gpio_oe_o;
	logic [4:0] gpio_drive_o;
	logic [7:0] int_event_i;
	logic [12:0] cmd_dl_value_i;
	logic [63:0] capture_ready_i;
	int n_mismatch, comparisons;
	agp_regs i_dut (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wr_i,
		.reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .gpio_in_i,
		.gpio_out_o, .gpio_oe_o, .gpio_drive_o, .int_event_i, .irq_o,
		.backlight_pwm_o, .play_volume_o(), .fx_volume_o(), .fx_select_o(),
		.fx_start_o(), .play_fetch_addr_o(), .play_tick_o(), .play_active_o,
		.play_encoding_o(), .cmd_read_adv_i, .cmd_pending_o,
		.cmd_read_ptr_o(), .cmd_write_ptr_o(), .cmd_dl_load_i,
		.cmd_dl_value_i, .cmd_dl_offset_o(), .macro0_o(), .macro1_o(),
		.capture_ready_i, .touch_mode_o(), .touch_select_o());
	// ****************************************
	// host access tasks
	// ****************************************
	task automatic test_done();
		if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc
	task automatic wr(input logic [21:0] a, input logic [31:0] d);
		@(negedge clk_sys_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
	endtask : wr
	// registered answer, taken at the next falling edge
	task automatic rdv(input logic [21:0] a, output logic [31:0] d);
		@(negedge clk_sys_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_i = 1'b0;
		chk(32'(reg_rvalid_o), 32'h1);
		d = reg_rdata_o;
	endtask : rdv
	task automatic rd(input logic [21:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rdv(a, d);
		chk(d, exp);
	endtask : rd
	// reset value, then all ones must read back as exactly w bits
	task automatic rw(input logic [21:0] a, input logic [31:0] r, input int w);
		rd(a, r);
		wr(a, 32'hffff_ffff);
		rd(a, ~(32'hffff_ffff << w));
	endtask : rw
	task automatic ev(input logic [7:0] e, input logic x);
		@(negedge clk_sys_i);
		int_event_i = e;
		@(negedge clk_sys_i);
		int_event_i = 8'h00;
		chk(32'(irq_o), 32'(x));
	endtask : ev
	// counts high cycles; the window spans whole pwm periods
	task automatic pwm(input logic [31:0] d, input int n, lo, hi);
		int c;
		wr(agp_pkg::OFF_BL_DUTY, d);
		cyc(3);
		c = 0;
		repeat (n) begin
			@(negedge clk_sys_i);
			if (backlight_pwm_o === 1'b1) c++;
		end
		chk(32'(c >= lo && c <= hi), 32'h1);
	endtask : pwm
	task automatic adv();
		@(negedge clk_sys_i);
		cmd_read_adv_i = 1'b1;
		@(negedge clk_sys_i);
		cmd_read_adv_i = 1'b0;
	endtask : adv
	// ****************************************
	// clock, watchdog and test sequence
	// ****************************************
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// whole run is near 9200 cycles
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		n_mismatch++;
		test_done();
	end
	initial begin
		{resetn_i, reg_wr_i, reg_rd_i, cmd_read_adv_i, cmd_dl_load_i} = 5'h00;
		reg_addr_i = 22'h00_0000;
		reg_wdata_i = 32'h0000_0000;
		gpio_in_i = 3'h2;
		int_event_i = 8'h00;
		cmd_dl_value_i = 13'h0000;
		capture_ready_i = 64'h1234_5678_9abc_def0;
		cyc(2);
		resetn_i = 1'b1;
		rw(agp_pkg::OFF_PLAY_VOL, 32'hff, 8);
		rw(agp_pkg::OFF_FX_VOL, 32'hff, 8);
		rw(agp_pkg::OFF_FX_SEL, 32'h0, 16);
		rw(agp_pkg::OFF_PIN_DIR, 32'h80, 8);
		rw(agp_pkg::OFF_PIN_VAL, 32'h0, 8);
		rw(agp_pkg::OFF_INT_EN, 32'h0, 1);
		rw(agp_pkg::OFF_INT_FLAG, 32'h0, 0);
		rw(agp_pkg::OFF_INT_MASK, 32'hff, 8);
		rw(agp_pkg::OFF_PLAY_START, 32'h0, 20);
		rw(agp_pkg::OFF_PLAY_LEN, 32'h0, 20);
		rw(agp_pkg::OFF_PLAY_RATE, 32'h1f40, 16);
		rw(agp_pkg::OFF_PLAY_ENC, 32'h0, 2);
		rw(agp_pkg::OFF_PLAY_LOOP, 32'h0, 1);
		rw(agp_pkg::OFF_BL_FREQ, 32'h00fa, 14);
		rw(agp_pkg::OFF_BL_DUTY, 32'h80, 8);
		rw(agp_pkg::OFF_MACRO0, 32'h0, 32);
		rw(agp_pkg::OFF_MACRO1, 32'h0, 32);
		rw(agp_pkg::OFF_CMD_RD, 32'h0, 12);
		rw(agp_pkg::OFF_CMD_WR, 32'h0, 12);
		rw(agp_pkg::OFF_CMD_DL, 32'h0, 13);
		rw(agp_pkg::OFF_TOUCH_MODE, 32'h3, 2);
		rw(agp_pkg::OFF_TOUCH_SEL, 32'h1, 1);
		rw(22'h10_24d0, 32'h0, 0);
		rd(agp_pkg::OFF_CAP_LO, 32'h9abc_def0);
		rd(agp_pkg::OFF_CAP_HI, 32'h1234_5678);
		rd(agp_pkg::OFF_PLAY_GO, 32'h0);
		chk(32'({gpio_oe_o, gpio_out_o, gpio_drive_o}), 32'h07ff);
		wr(agp_pkg::OFF_PIN_DIR, 32'h81);
		wr(agp_pkg::OFF_PIN_VAL, 32'h85);
		rd(agp_pkg::OFF_PIN_VAL, 32'h87);
		chk(32'({gpio_oe_o, gpio_out_o, gpio_drive_o}), 32'h05a1);
		ev(8'h05, 1'b1);
		rd(agp_pkg::OFF_INT_FLAG, 32'h05);
		chk(32'(irq_o), 32'h0);
		rd(agp_pkg::OFF_INT_FLAG, 32'h00);
		wr(agp_pkg::OFF_INT_MASK, 32'hfe);
		ev(8'h01, 1'b0);
		rd(agp_pkg::OFF_INT_FLAG, 32'h01);
		ev(8'h02, 1'b1);
		wr(agp_pkg::OFF_INT_EN, 32'h0);
		cyc(2);
		chk(32'(irq_o), 32'h0);
		pwm(32'h00, 1300, 0, 0);
		pwm(32'h80, 1300, 1300, 1300);
		pwm(32'h40, 2442, 1190, 1252);
		wr(agp_pkg::OFF_PLAY_START, 32'h100);
		wr(agp_pkg::OFF_PLAY_LEN, 32'h3);
		wr(agp_pkg::OFF_PLAY_LOOP, 32'h0);
		wr(agp_pkg::OFF_PLAY_GO, 32'h1);
		rd(agp_pkg::OFF_PLAY_GO, 32'h1);
		chk(32'(play_active_o), 32'h1);
		rdv(agp_pkg::OFF_PLAY_PTR, v);
		chk(32'(v >= 32'h100 && v <= 32'h102), 32'h1);
		cyc(1300);
		rd(agp_pkg::OFF_PLAY_GO, 32'h0);
		wr(agp_pkg::OFF_PLAY_LOOP, 32'h1);
		wr(agp_pkg::OFF_PLAY_GO, 32'h1);
		cyc(1300);
		wr(agp_pkg::OFF_PLAY_GO, 32'h0);
		rd(agp_pkg::OFF_PLAY_GO, 32'h1);
		rdv(agp_pkg::OFF_PLAY_PTR, v);
		chk(32'(v >= 32'h100 && v <= 32'h102), 32'h1);
		wr(agp_pkg::OFF_PLAY_LOOP, 32'h0);
		cyc(1300);
		rd(agp_pkg::OFF_PLAY_GO, 32'h0);
		wr(agp_pkg::OFF_CMD_WR, 32'h1);
		cyc(2);
		chk(32'(cmd_pending_o), 32'h1);
		adv();
		adv();
		cyc(2);
		chk(32'(cmd_pending_o), 32'h0);
		rd(agp_pkg::OFF_CMD_RD, 32'h001);
		@(negedge clk_sys_i);
		cmd_dl_value_i = 13'h1abc;
		cmd_dl_load_i = 1'b1;
		@(negedge clk_sys_i);
		cmd_dl_load_i = 1'b0;
		rd(agp_pkg::OFF_CMD_DL, 32'h1abc);
		test_done();
	end
endmodule : tb_audio_gpio_pwm_cmd_regs
